// ---- design/power_mode_controller.sv ----
// Notes on behaviour
// - Four modes only: full-run, reduced-run, sleep, hibernate, in falling consumption.
// - In full-run each subsystem except the CPU follows its own template bit; the CPU bit is also set by wakeups and cleared by self-disable.
// - Full-run entered by wakeup, reset or firmware write; any interrupt wakes.
// - Reduced-run entered only by firmware write; any interrupt wakes it.
// - Sleep disables all subsystems, ignoring templates.
// - Sleep by write only; slow clocks run; six named wake sources, plus the sleep timer and the one-second tick.
// - Sleep supports timed intervals and keeps timekeeping alive.
// - Watch crystal feeds sleep timer and raises a one-second tick.
// - Hibernate by write only; stops all clocks; pin unit wakes only.
// - Hibernate retains state, no clocks, wakes only from pin events.
// - Every wakeup returns to full-run and re-enables the processor.
// - After reset the mode is full-run.
`timescale 1ns/100ps
`default_nettype none
module power_mode_controller (
    // Clock and reset
    input  wire logic       mclk_i,
    input  wire logic       rst_b_i,
    // Firmware mode request
    input  wire logic       mode_req_i,
    input  wire logic [1:0] mode_sel_i,
    // Templates for full-run and reduced-run, and the processor self-disable request
    input  wire logic [7:0] full_template_i,
    input  wire logic [7:0] reduced_template_i,
    input  wire logic       cpu_off_i,
    // Interrupt and wake sources, asynchronous pins
    input  wire logic       any_irq_i,
    input  wire logic [5:0] sleep_wake_i,
    input  wire logic       pin_interrupt_unit_i,
    input  wire logic       external_reset_pin_b_i,
    input  wire logic       watchdog_reset_i,
    // Slow clocks, sampled as plain inputs
    input  wire logic       internal_low_speed_osc_i,
    input  wire logic       watch_crystal_osc_i,
    // Timed sleep interval
    input  wire logic [15:0] sleep_interval_i,
    input  wire logic        sleep_timer_en_i,
    // Status
    output logic [1:0]      mode_o,
    output logic [7:0]      subsys_en_o,
    output logic            cpu_en_o,
    output logic            clocks_run_o,
    output logic            slow_clk_run_o,
    output logic            second_tick_o,
    output logic            wake_pulse_o,
    output logic            reset_event_o,
    // Gated subsystem clocks
    output logic [7:0]      subsys_gclk_o
);
    pmc_pkg::power_mode_t mode_reg;
    pmc_pkg::power_mode_t mode_next;

    // Two-flop synchronisers for all off-domain inputs
    localparam int SYNC_W = 12;
    logic [SYNC_W-1:0] sync1_reg;
    logic [SYNC_W-1:0] sync2_reg;
    logic [SYNC_W-1:0] sync_in;

    assign sync_in = {watch_crystal_osc_i, internal_low_speed_osc_i, ~external_reset_pin_b_i,
                      watchdog_reset_i, pin_interrupt_unit_i, any_irq_i, sleep_wake_i};

    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            sync1_reg <= '0;
            sync2_reg <= '0;
        end else begin
            sync1_reg <= sync_in;
            sync2_reg <= sync1_reg;
        end
    end

    logic [5:0] wake_src;
    logic       irq_s;
    logic       pin_s;
    logic       wdr_s;
    logic       external_reset_pin_s;
    logic       ilo_s;
    logic       xtal_s;
    assign wake_src = sync2_reg[5:0];
    assign irq_s    = sync2_reg[6];
    assign pin_s    = sync2_reg[7];
    assign wdr_s    = sync2_reg[8];
    assign external_reset_pin_s   = sync2_reg[9];
    assign ilo_s    = sync2_reg[10];
    assign xtal_s   = sync2_reg[11];

    // Crystal edge detect on the synchronised copy only
    logic xtal_d_reg;
    logic xtal_rise;
    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            xtal_d_reg <= 1'b0;
        end else begin
            xtal_d_reg <= xtal_s;
        end
    end
    assign xtal_rise = xtal_s & ~xtal_d_reg;

    // One-second tick from the watch crystal
    logic [14:0] sec_cnt_reg;
    logic        second_tick_reg;
    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            sec_cnt_reg     <= '0;
            second_tick_reg <= 1'b0;
        end else begin
            second_tick_reg <= 1'b0;
            if (mode_reg != pmc_pkg::MODE_HIBERNATE && xtal_rise) begin
                if (sec_cnt_reg == pmc_pkg::SECOND_TICKS_M1) begin
                    sec_cnt_reg     <= '0;
                    second_tick_reg <= 1'b1;
                end else begin
                    sec_cnt_reg <= sec_cnt_reg + 15'h0001;
                end
            end
        end
    end

    // Sleep timer clocked by crystal edges, counts only while asleep
    logic [15:0] sleep_tmr_reg;
    logic        sleep_tmr_wake;
    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            sleep_tmr_reg <= pmc_pkg::SLEEP_TMR_RESET;
        end else if (mode_reg != pmc_pkg::MODE_SLEEP) begin
            sleep_tmr_reg <= pmc_pkg::SLEEP_TMR_RESET;
        end else if (xtal_rise) begin
            sleep_tmr_reg <= sleep_tmr_reg + 16'h0001;
        end
    end
    assign sleep_tmr_wake = sleep_timer_en_i && (sleep_tmr_reg >= sleep_interval_i)
                            && (mode_reg == pmc_pkg::MODE_SLEEP);

    // Wake qualification per mode
    logic reset_evt;
    logic wake_evt;
    assign reset_evt = external_reset_pin_s | wdr_s;
    always_comb begin
        unique case (mode_reg)
            pmc_pkg::MODE_FULL_RUN:    wake_evt = irq_s;
            pmc_pkg::MODE_REDUCED_RUN: wake_evt = irq_s;
            pmc_pkg::MODE_SLEEP:       wake_evt = (|wake_src) | sleep_tmr_wake | second_tick_reg;
            pmc_pkg::MODE_HIBERNATE:   wake_evt = pin_s;
        endcase
    end

    // Mode sequencer; wake and reset win over a same-cycle request
    always_comb begin
        mode_next = mode_reg;
        if (reset_evt || wake_evt) begin
            mode_next = pmc_pkg::MODE_FULL_RUN;
        end else if (mode_req_i) begin
            unique case (mode_sel_i)
                pmc_pkg::REQ_FULL_RUN:    mode_next = pmc_pkg::MODE_FULL_RUN;
                pmc_pkg::REQ_REDUCED_RUN: mode_next = pmc_pkg::MODE_REDUCED_RUN;
                pmc_pkg::REQ_SLEEP:       mode_next = pmc_pkg::MODE_SLEEP;
                pmc_pkg::REQ_HIBERNATE:   mode_next = pmc_pkg::MODE_HIBERNATE;
            endcase
        end
    end

    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            mode_reg <= pmc_pkg::MODE_FULL_RUN;
        end else begin
            mode_reg <= mode_next;
        end
    end

    // Processor self-disable, cleared by any wakeup
    logic cpu_off_reg;
    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            cpu_off_reg <= 1'b0;
        end else if (reset_evt || wake_evt) begin
            cpu_off_reg <= 1'b0;
        end else if (cpu_off_i) begin
            cpu_off_reg <= 1'b1;
        end
    end

    // Enable vector from the next mode so enables track mode exactly
    function automatic logic [7:0] mode_enables(input pmc_pkg::power_mode_t m,
                                                input logic [7:0] full_t,
                                                input logic [7:0] red_t);
        unique case (m)
            pmc_pkg::MODE_FULL_RUN:    mode_enables = full_t;
            pmc_pkg::MODE_REDUCED_RUN: mode_enables = red_t;
            pmc_pkg::MODE_SLEEP:       mode_enables = 8'h00;
            pmc_pkg::MODE_HIBERNATE:   mode_enables = 8'h00;
        endcase
    endfunction : mode_enables

    logic [7:0] en_next;
    logic       wake_now;
    assign wake_now = reset_evt | wake_evt;
    always_comb begin
        en_next = mode_enables(mode_next, full_template_i, reduced_template_i);
        if (wake_now) begin
            en_next[pmc_pkg::CPU_BIT] = 1'b1;
        end else if (cpu_off_reg || cpu_off_i) begin
            en_next[pmc_pkg::CPU_BIT] = 1'b0;
        end
    end

    // Registered outputs
    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            mode_o         <= pmc_pkg::MODE_FULL_RUN;
            subsys_en_o    <= pmc_pkg::TEMPLATE_RESET;
            cpu_en_o       <= 1'b1;
            clocks_run_o   <= 1'b1;
            slow_clk_run_o <= 1'b1;
            second_tick_o  <= 1'b0;
            wake_pulse_o   <= 1'b0;
            reset_event_o  <= 1'b0;
        end else begin
            mode_o         <= mode_next;
            subsys_en_o    <= en_next;
            cpu_en_o       <= en_next[pmc_pkg::CPU_BIT];
            clocks_run_o   <= (mode_next == pmc_pkg::MODE_FULL_RUN) ||
                              (mode_next == pmc_pkg::MODE_REDUCED_RUN);
            slow_clk_run_o <= (mode_next != pmc_pkg::MODE_HIBERNATE);
            second_tick_o  <= second_tick_reg;
            wake_pulse_o   <= wake_evt && (mode_reg != pmc_pkg::MODE_FULL_RUN);
            reset_event_o  <= reset_evt;
        end
    end

    // Gate off disabled subsystems' clocks
    pmc_subsys_gate u_gate (
        .mclk_i   (mclk_i),
        .rst_b_i  (rst_b_i),
        .enable_i (subsys_en_o),
        .gclk_o   (subsys_gclk_o)
    );

    logic unused_ilo;
    assign unused_ilo = ilo_s;
endmodule : power_mode_controller
`default_nettype wire

// ---- design/pmc_pkg.sv ----
package pmc_pkg;
    // Global power modes, highest to lowest consumption
    typedef enum logic [1:0] {
        MODE_FULL_RUN    = 2'b00,
        MODE_REDUCED_RUN = 2'b01,
        MODE_SLEEP       = 2'b10,
        MODE_HIBERNATE   = 2'b11
    } power_mode_t;

    // Mode request command codes
    localparam logic [1:0] REQ_FULL_RUN    = 2'h0;
    localparam logic [1:0] REQ_REDUCED_RUN = 2'h1;
    localparam logic [1:0] REQ_SLEEP       = 2'h2;
    localparam logic [1:0] REQ_HIBERNATE   = 2'h3;

    // Subsystem template layout
    localparam int          NUM_SUBSYS       = 8;
    localparam int          CPU_BIT          = 0;
    localparam logic [7:0]  TEMPLATE_RESET   = 8'hff;

    // Sleep wake sources, one bit each
    localparam int          NUM_WAKE         = 6;
    localparam int          WAKE_CMP_BIT     = 0;
    localparam int          WAKE_PIN_BIT     = 1;
    localparam int          WAKE_I2C_BIT     = 2;
    localparam int          WAKE_RTC_BIT     = 3;
    localparam int          WAKE_CTW_BIT     = 4;
    localparam int          WAKE_LVD_BIT     = 5;

    // Watch crystal: 32768 ticks give one second
    localparam int          CRYSTAL_HZ       = 32768;
    localparam logic [14:0] SECOND_TICKS_M1  = 15'(CRYSTAL_HZ - 1);
    localparam logic [15:0] SLEEP_TMR_RESET  = 16'h0000;
endpackage : pmc_pkg

// ---- design/pmc_subsys_gate.sv ----
`timescale 1ns/100ps
`default_nettype none
module pmc_subsys_gate (
    // Clock and reset
    input  wire logic       mclk_i,
    input  wire logic       rst_b_i,
    // Enable vector
    input  wire logic [7:0] enable_i,
    // Gated clocks
    output logic [7:0]      gclk_o
);
    logic [7:0] latch_en_reg;

    // Latch on low phase so the gate never slivers a pulse
    always_latch begin
        if (!mclk_i) begin
            latch_en_reg = enable_i;
        end
    end

    assign gclk_o = {8{mclk_i}} & latch_en_reg & {8{rst_b_i}};
endmodule : pmc_subsys_gate
`default_nettype wire

// ---- dv/pmc_checker.sv ----
`timescale 1ns/100ps
`default_nettype none
module pmc_checker (
    // Clock and reset
    input wire logic       mclk_i,
    input wire logic       rst_b_i,
    // Watched inputs
    input wire logic       mode_req_i,
    input wire logic [1:0] mode_sel_i,
    input wire logic [7:0] full_template_i,
    input wire logic       any_irq_i,
    input wire logic [5:0] sleep_wake_i,
    input wire logic       pin_interrupt_unit_i,
    input wire logic       external_reset_pin_b_i,
    input wire logic       watchdog_reset_i,
    input wire logic       watch_crystal_osc_i,
    // Watched outputs
    input wire logic [1:0] mode_o,
    input wire logic [7:0] subsys_en_o,
    input wire logic       cpu_en_o,
    input wire logic       clocks_run_o,
    input wire logic       slow_clk_run_o,
    input wire logic       wake_pulse_o
);
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!rst_b_i);
    // Requests race wakes; only judge them once the sync pipes are empty
    logic [2:0] quiet_reg;
    logic       idle;
    assign idle = !any_irq_i && sleep_wake_i == 6'h00 && !pin_interrupt_unit_i
                  && external_reset_pin_b_i && !watchdog_reset_i;
    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            quiet_reg <= 3'h0;
        end else if (!idle || watch_crystal_osc_i != $past(watch_crystal_osc_i)) begin
            quiet_reg <= 3'h0;
        end else if (quiet_reg != 3'h7) begin
            quiet_reg <= quiet_reg + 3'h1;
        end
    end
    sequence hib_quiet;
        (mode_o == pmc_pkg::MODE_HIBERNATE && !mode_req_i && !pin_interrupt_unit_i
         && external_reset_pin_b_i && !watchdog_reset_i)[*4];
    endsequence
    chk_req_mode_next: assert property (mode_req_i && quiet_reg >= 3'h4 |=> mode_o == $past(mode_sel_i))
        else $error("mode did not follow request");
    chk_sleep_gates_all: assert property (mode_o == pmc_pkg::MODE_SLEEP |-> subsys_en_o == 8'h00 && !clocks_run_o)
        else $error("sleep left subsystems or clocks on");
    chk_hib_no_clocks: assert property (mode_o == pmc_pkg::MODE_HIBERNATE |-> !clocks_run_o && !slow_clk_run_o)
        else $error("hibernate left clocks running");
    chk_full_follows_template: assert property ($past(rst_b_i) && mode_o == pmc_pkg::MODE_FULL_RUN
        && $past(mode_o) == pmc_pkg::MODE_FULL_RUN && $stable(full_template_i)
        |-> subsys_en_o[7:1] == full_template_i[7:1]) else $error("full-run enables differ from template");
    chk_cpu_bit_tied: assert property (cpu_en_o == subsys_en_o[pmc_pkg::CPU_BIT])
        else $error("cpu enable differs from its enable bit");
    chk_wake_pulse_one: assert property (wake_pulse_o |=> !wake_pulse_o)
        else $error("wake pulse longer than one cycle");
    chk_wake_to_full: assert property (wake_pulse_o |-> mode_o == pmc_pkg::MODE_FULL_RUN && cpu_en_o)
        else $error("wake did not give full-run with cpu");
    chk_hib_stays_put: assert property (hib_quiet |=> mode_o == pmc_pkg::MODE_HIBERNATE)
        else $error("hibernate left without pin event");
    chk_reset_full_run: assert property ($rose(rst_b_i) |-> mode_o == pmc_pkg::MODE_FULL_RUN && clocks_run_o)
        else $error("reset did not give full-run");
endmodule : pmc_checker
bind power_mode_controller pmc_checker i_chk (.mclk_i(mclk_i), .rst_b_i(rst_b_i), .mode_req_i(mode_req_i),
    .mode_sel_i(mode_sel_i), .full_template_i(full_template_i), .any_irq_i(any_irq_i),
    .sleep_wake_i(sleep_wake_i), .pin_interrupt_unit_i(pin_interrupt_unit_i),
    .external_reset_pin_b_i(external_reset_pin_b_i), .watchdog_reset_i(watchdog_reset_i),
    .watch_crystal_osc_i(watch_crystal_osc_i), .mode_o(mode_o), .subsys_en_o(subsys_en_o), .cpu_en_o(cpu_en_o),
    .clocks_run_o(clocks_run_o), .slow_clk_run_o(slow_clk_run_o), .wake_pulse_o(wake_pulse_o));
`default_nettype wire

// ---- dv/tb_top.sv ----
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    logic        mclk_i = 1'b0;
    logic        rst_b_i = 1'b0;
    logic        req = 1'b0;
    logic [1:0]  sel = 2'h0;
    logic [7:0]  full_t = pmc_pkg::TEMPLATE_RESET;
    logic [7:0]  red_t = 8'h00;
    logic [9:0]  src = 10'h000;
    logic [1:0]  mode;
    logic [7:0]  en;
    logic        cpu, run, slow, wk;
    logic        xtal = 1'b0;
    logic        tmr_en = 1'b0;
    logic        cpu_off = 1'b0;
    logic        rst_ev;
    logic [31:0] lfsr = 32'h5a89b2a3;
    int          n_fail = 0;
    int          checks = 0;
    int          cyc = 0;
    always #4 mclk_i = ~mclk_i;
    always @(posedge mclk_i) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            n_fail++;
            finish_test();
        end
    end
    // A full second needs far too many cycles; the sleep timer runs a short interval of 3 ticks
    power_mode_controller i_dut (.mclk_i(mclk_i), .rst_b_i(rst_b_i), .mode_req_i(req), .mode_sel_i(sel),
        .full_template_i(full_t), .reduced_template_i(red_t), .cpu_off_i(cpu_off), .any_irq_i(src[6]),
        .sleep_wake_i(src[5:0]), .pin_interrupt_unit_i(src[7]), .external_reset_pin_b_i(!src[8]),
        .watchdog_reset_i(src[9]), .internal_low_speed_osc_i(1'b0), .watch_crystal_osc_i(xtal),
        .sleep_interval_i(16'h0003), .sleep_timer_en_i(tmr_en), .mode_o(mode), .subsys_en_o(en), .cpu_en_o(cpu),
        .clocks_run_o(run), .slow_clk_run_o(slow), .second_tick_o(), .wake_pulse_o(wk), .reset_event_o(rst_ev),
        .subsys_gclk_o());
    function automatic logic [31:0] rnd();
        lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
        return lfsr;
    endfunction : rnd
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task automatic finish_test();
        $display("checks=%0d n_fail=%0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : finish_test
    task automatic ask(input logic [1:0] m);
        @(posedge mclk_i);
        #1;
        req = 1'b1;
        sel = m;
        @(posedge mclk_i);
        #1;
        req = 1'b0;
    endtask : ask
    task automatic state(input logic [1:0] m);
        logic [7:0] e;
        e = (m == 2'h0) ? full_t : (m == 2'h1) ? red_t : 8'h00;
        chk({6'h00, mode}, {6'h00, m});
        chk(en, e);
        chk({5'h00, cpu, run, slow}, {5'h00, e[0], m < 2'h2, m != 2'h3});
    endtask : state
    // Holds the source until full-run shows, bounded by the sync latency
    task automatic wake(input logic [9:0] v);
        int i;
        @(posedge mclk_i);
        #1;
        src = v;
        for (i = 0; i < 8 && mode !== 2'h0; i++) begin
            @(posedge mclk_i);
            #1;
        end
        chk({6'h00, mode}, 8'h00);
        chk({7'h00, cpu}, 8'h01);
        chk({7'h00, rst_ev}, {7'h00, |v[9:8]});
        if (v[9:8] == 2'h0) chk({7'h00, wk}, 8'h01);
        src = 10'h000;
        @(posedge mclk_i);
        #1;
        chk({7'h00, wk}, 8'h00);
    endtask : wake
    // One crystal period, long enough to pass the synchroniser
    task automatic xtick();
        xtal = 1'b1;
        repeat (4) @(posedge mclk_i);
        #1;
        xtal = 1'b0;
        repeat (4) @(posedge mclk_i);
        #1;
    endtask : xtick
    initial begin
        repeat (2) @(posedge mclk_i);
        #1;
        rst_b_i = 1'b1;
        state(2'h0);
        $display("test reset done");
        for (int r = 0; r < 6; r++) begin
            full_t = rnd() | 8'h01;
            red_t = rnd();
            ask(pmc_pkg::REQ_REDUCED_RUN);
            state(2'h1);
            wake(10'h040);
            ask(pmc_pkg::REQ_SLEEP);
            state(2'h2);
            wake(10'h001 << r);
            ask(pmc_pkg::REQ_HIBERNATE);
            state(2'h3);
            src = 10'h07f;
            repeat (6) @(posedge mclk_i);
            #1;
            state(2'h3);
            src = 10'h000;
            wake(10'h080);
            ask(pmc_pkg::REQ_FULL_RUN);
            state(2'h0);
        end
        $display("test modes done");
        ask(pmc_pkg::REQ_SLEEP);
        wake(10'h100);
        ask(pmc_pkg::REQ_HIBERNATE);
        wake(10'h100);
        ask(pmc_pkg::REQ_REDUCED_RUN);
        wake(10'h200);
        $display("test reset events done");
        tmr_en = 1'b1;
        ask(pmc_pkg::REQ_SLEEP);
        xtick();
        xtick();
        state(2'h2);
        xtick();
        chk({6'h00, mode}, 8'h00);
        chk({7'h00, cpu}, 8'h01);
        tmr_en = 1'b0;
        $display("test sleep timer done");
        cpu_off = 1'b1;
        @(posedge mclk_i);
        #1;
        cpu_off = 1'b0;
        @(posedge mclk_i);
        #1;
        chk({7'h00, cpu}, 8'h00);
        src = 10'h040;
        repeat (4) @(posedge mclk_i);
        #1;
        chk({7'h00, cpu}, 8'h01);
        src = 10'h000;
        repeat (4) @(posedge mclk_i);
        #1;
        chk({7'h00, cpu}, 8'h01);
        $display("test cpu self-disable done");
        finish_test();
    end
endmodule : tb_top
`default_nettype wire
